// ### shared/cmon_pkg.sv
// cell monitor register bank: shared constants, field layouts and carriers
// assumes one 10 MHz clock and a byte-addressed Avalon-MM slave port
//
// Behaviour
// (R1) aux group B: gpio4, gpio5, ref2, low first
// (R2) status A: cell sum, die temp, analog supply
// (R3) status B: digital supply, then packed cell flags
// (R4) last byte: revision, reserved, self-test, thermal
// (R5) three bus slots: lead code, byte, trail
// (R6) keep-reference bit holds reference until watchdog
// (R7) timer pin state bit mirrors the pin
// (R8) under level is (code+1) times sixteen steps
// (R9) over level is code times sixteen steps
// (R10) drain bit set closes that cell's switch
// (R11) writes to result and status groups ignored
package cmon_pkg;

	// ==========================================================
	// sizes
	localparam int NCELL      = 12;
	localparam int NSLOT      = 3;
	localparam int GRP_BYTES  = 6;
	localparam int IRQ_W      = 5;
	localparam int THR_W      = 12;
	localparam int STEP_SHIFT = 4;

	// ==========================================================
	// byte addresses, one aligned word per register
	localparam logic [7:0] OFF_AUXB     = 8'h00;
	localparam logic [7:0] OFF_STA      = 8'h18;
	localparam logic [7:0] OFF_STB      = 8'h30;
	localparam logic [7:0] OFF_BUSM     = 8'h48;
	localparam logic [7:0] GRP_SPAN     = 8'h18;
	localparam logic [7:0] OFF_REF_CTRL = 8'h60;
	localparam logic [7:0] OFF_UNDER    = 8'h64;
	localparam logic [7:0] OFF_OVER     = 8'h68;
	localparam logic [7:0] OFF_DRAIN    = 8'h6C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h70;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h74;

	// ==========================================================
	// field positions
	localparam int REF_KEEP_BIT  = 0;
	localparam int TIMER_PIN_BIT = 1;
	localparam int SELFTEST_BIT  = 1;
	localparam int THERMAL_BIT   = 0;
	localparam int REV_LSB       = 4;
	localparam int IRQ_AUXB      = 0;
	localparam int IRQ_STAT      = 1;
	localparam int IRQ_FLAG      = 2;
	localparam int IRQ_SELFTEST  = 3;
	localparam int IRQ_THERMAL   = 4;

	// ==========================================================
	// values after reset
	localparam logic [THR_W-1:0] UNDER_RST = 12'h000;
	localparam logic [THR_W-1:0] OVER_RST  = 12'h000;
	localparam logic [NCELL-1:0] DRAIN_RST = 12'h000;
	localparam logic             KEEP_RST  = 1'h0;
	localparam logic [IRQ_W-1:0] MASK_RST  = 5'h00;
	localparam logic [7:0]       BYTE_RST  = 8'h00;
	localparam logic [15:0]      RES_RST   = 16'h0000;
	// revision value is arbitrary
	localparam logic [3:0]       REV_DEF   = 4'h0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [15:0] gpio4_result;
		logic [15:0] gpio5_result;
		logic [15:0] ref2_result;
	} cmon_auxb_t;

	typedef struct packed {
		logic [15:0] cell_sum_result;
		logic [15:0] die_temperature_result;
		logic [15:0] analog_supply_result;
	} cmon_stata_t;

	typedef struct packed {
		logic [3:0] leading_control_code;
		logic [7:0] transfer_byte;
		logic [3:0] trailing_control_code;
	} cmon_slot_t;

	typedef cmon_slot_t [NSLOT-1:0] cmon_slots_t;
	typedef logic [NCELL-1:0][15:0] cmon_cells_t;

endpackage

// ### design/cmon_sync2.sv
// two-flop synchroniser for levels arriving from pins
// assumes the destination runs on clk_sys_i
module cmon_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i, // system clock
	input  wire logic         sys_rst_i, // sync reset, high
	input  wire logic [W-1:0] async_i,   // pin level
	output logic      [W-1:0] sync_o     // synchronised level
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule

// ### design/cmon_cell_cmp.sv
// threshold comparator for one cell result
// assumes result and codes share the 100 uV unit scale
module cmon_cell_cmp
	import cmon_pkg::*;
(
	input  wire logic [15:0]      cell_i,  // cell result
	input  wire logic [THR_W-1:0] under_i, // under code
	input  wire logic [THR_W-1:0] over_i,  // over code
	output logic                  under_o, // below under level
	output logic                  over_o   // above over level
);
	logic [THR_W+STEP_SHIFT:0] under_lvl;
	logic [THR_W+STEP_SHIFT:0] over_lvl;

	// 17 bits so code 0xFFF plus one does not wrap
	assign under_lvl = {1'b0, under_i, 4'h0} + 17'h00010; // R8
	assign over_lvl  = {1'b0, over_i, 4'h0};              // R9
	assign under_o   = {1'b0, cell_i} < under_lvl;        // R8
	assign over_o    = {1'b0, cell_i} > over_lvl;         // R9
endmodule

// ### design/cmon_bank.sv
// result, status, bus-master and configuration register bank
// assumes measurement strobes and levels come from logic on clk_sys_i;
// only the timer enable pin is asynchronous
//
// Chosen here: the address map and the Avalon-MM register port.
module cmon_bank
	import cmon_pkg::*;
#(
	parameter logic [3:0] REVISION = REV_DEF
) (
	input  wire logic                clk_sys_i,          // 10 MHz clock
	input  wire logic                sys_rst_i,          // sync reset, high
	// avalon-mm slave
	input  wire logic [7:0]          avs_address_i,      // byte address
	input  wire logic                avs_read_i,         // read request
	input  wire logic                avs_write_i,        // write request
	input  wire logic [31:0]         avs_writedata_i,    // write data
	input  wire logic [3:0]          avs_byteenable_i,   // byte lanes
	output logic      [31:0]         avs_readdata_o,     // read data
	output logic                     avs_waitrequest_o,  // stall
	output logic                     irq_o,              // level interrupt
	// measurement side
	input  wire cmon_pkg::cmon_auxb_t  auxb_i,           // aux results B
	input  wire logic                  auxb_valid_i,     // aux B done
	input  wire cmon_pkg::cmon_stata_t stata_i,          // status A results
	input  wire logic [15:0]           digital_supply_i, // digital supply
	input  wire logic                  stat_valid_i,     // status done
	input  wire cmon_pkg::cmon_cells_t cells_i,          // cell results
	input  wire logic                  cells_valid_i,    // cells done
	input  wire logic                  selftest_fail_i,  // mux self-test
	input  wire logic                  thermal_i,        // thermal shutdown
	input  wire logic                  conv_busy_i,      // conversion active
	input  wire logic                  wdt_timeout_i,    // watchdog pulse
	input  wire logic                  timer_enable_pin_i, // pin, async
	// control outputs
	output logic                       ref_power_o,      // reference on
	output logic      [NCELL-1:0]      drain_switch_o,   // switch closed
	output cmon_pkg::cmon_slots_t      bus_slots_o       // bus-master slots
);

	// ==========================================================
	// declarations
	logic                 ack_q;
	logic                 wr_en;
	logic                 rd_first;
	logic [31:0]          rd_data_c;
	logic [31:0]          readdata_q;
	cmon_auxb_t           auxb_q;
	cmon_stata_t          stata_q;
	logic [15:0]          vd_q;
	logic [NCELL-1:0]     under_flag_q;
	logic [NCELL-1:0]     over_flag_q;
	logic [NCELL-1:0]     under_c;
	logic [NCELL-1:0]     over_c;
	logic                 selftest_q;
	logic                 thermal_q;
	logic [7:0]           busm_q [GRP_BYTES];
	logic                 keep_ref_q;
	logic [THR_W-1:0]     under_code_q;
	logic [THR_W-1:0]     over_code_q;
	logic [NCELL-1:0]     drain_q;
	logic                 ref_power_q;
	logic                 timer_pin_s;
	logic [IRQ_W-1:0]     irq_stat_q;
	logic [IRQ_W-1:0]     irq_mask_q;
	logic [IRQ_W-1:0]     irq_ev;
	logic [IRQ_W-1:0]     irq_clr;
	logic                 irq_q;
	logic [7:0]           auxb_b [GRP_BYTES];
	logic [7:0]           sta_b  [GRP_BYTES];
	logic [7:0]           stb_b  [GRP_BYTES];
	logic [2*NCELL-1:0]   cell_bits;
	logic [7:0]           grp_off;
	logic [2:0]           grp_idx;
	logic                 in_auxb;
	logic                 in_sta;
	logic                 in_stb;
	logic                 in_busm;
	logic [31:0]          wmask;

	// ==========================================================
	// bus handshake
	// every access takes exactly one wait cycle: the request is seen
	// with ack_q low, waitrequest drops in the next cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
		end
	end

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign wr_en             = avs_write_i & ack_q;
	assign rd_first          = avs_read_i & ~ack_q;

	// per-lane write mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = {8{avs_byteenable_i[i]}};
		end
	end

	// ==========================================================
	// address decode
	assign in_auxb = (avs_address_i >= OFF_AUXB) && (avs_address_i < OFF_AUXB + GRP_SPAN);
	assign in_sta  = (avs_address_i >= OFF_STA)  && (avs_address_i < OFF_STA + GRP_SPAN);
	assign in_stb  = (avs_address_i >= OFF_STB)  && (avs_address_i < OFF_STB + GRP_SPAN);
	assign in_busm = (avs_address_i >= OFF_BUSM) && (avs_address_i < OFF_BUSM + GRP_SPAN);

	always_comb begin
		grp_off = 8'h00;
		if (in_auxb) begin
			grp_off = avs_address_i - OFF_AUXB;
		end else if (in_sta) begin
			grp_off = avs_address_i - OFF_STA;
		end else if (in_stb) begin
			grp_off = avs_address_i - OFF_STB;
		end else if (in_busm) begin
			grp_off = avs_address_i - OFF_BUSM;
		end
	end

	assign grp_idx = grp_off[4:2];

	// ==========================================================
	// result groups
	// results change only on their own strobes; the bus cannot touch them
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			auxb_q <= '0;
		end else if (auxb_valid_i) begin
			auxb_q <= auxb_i; // R11
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			stata_q <= '0;
			vd_q    <= RES_RST;
		end else if (stat_valid_i) begin
			stata_q <= stata_i;          // R11
			vd_q    <= digital_supply_i; // R11
		end
	end

	// byte views, low byte first
	always_comb begin
		auxb_b[0] = auxb_q.gpio4_result[7:0];  // R1
		auxb_b[1] = auxb_q.gpio4_result[15:8]; // R1
		auxb_b[2] = auxb_q.gpio5_result[7:0];  // R1
		auxb_b[3] = auxb_q.gpio5_result[15:8]; // R1
		auxb_b[4] = auxb_q.ref2_result[7:0];   // R1
		auxb_b[5] = auxb_q.ref2_result[15:8];  // R1
	end

	always_comb begin
		sta_b[0] = stata_q.cell_sum_result[7:0];         // R2
		sta_b[1] = stata_q.cell_sum_result[15:8];        // R2
		sta_b[2] = stata_q.die_temperature_result[7:0];  // R2
		sta_b[3] = stata_q.die_temperature_result[15:8]; // R2
		sta_b[4] = stata_q.analog_supply_result[7:0];    // R2
		sta_b[5] = stata_q.analog_supply_result[15:8];   // R2
	end

	// ==========================================================
	// cell threshold flags
	generate
		for (genvar c = 0; c < NCELL; c++) begin : g_cell
			cmon_cell_cmp u_cmp (
				.cell_i  (cells_i[c]),
				.under_i (under_code_q),
				.over_i  (over_code_q),
				.under_o (under_c[c]),
				.over_o  (over_c[c])
			);
			// under in the even bit, over in the odd bit, cell 1 lowest
			assign cell_bits[2*c]   = under_flag_q[c]; // R3
			assign cell_bits[2*c+1] = over_flag_q[c];  // R3
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			under_flag_q <= '0;
			over_flag_q  <= '0;
		end else if (cells_valid_i) begin
			under_flag_q <= under_c; // R8
			over_flag_q  <= over_c;  // R9
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			selftest_q <= 1'b0;
			thermal_q  <= 1'b0;
		end else begin
			selftest_q <= selftest_fail_i;
			thermal_q  <= thermal_i;
		end
	end

	always_comb begin
		stb_b[0] = vd_q[7:0];   // R3
		stb_b[1] = vd_q[15:8];  // R3
		stb_b[2] = cell_bits[7:0];   // R3
		stb_b[3] = cell_bits[15:8];  // R3
		stb_b[4] = cell_bits[23:16]; // R3
		stb_b[5] = 8'h00;
		stb_b[5][REV_LSB +: 4]  = REVISION;   // R4
		stb_b[5][SELFTEST_BIT]  = selftest_q; // R4
		stb_b[5][THERMAL_BIT]   = thermal_q;  // R4
	end

	// ==========================================================
	// bus-master slots
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < GRP_BYTES; i++) begin
				busm_q[i] <= BYTE_RST;
			end
		end else if (wr_en && in_busm && avs_byteenable_i[0]) begin
			busm_q[grp_idx] <= avs_writedata_i[7:0]; // R5
		end
	end

	// first byte: lead code and upper data nibble; second: lower nibble and trail
	always_comb begin
		for (int s = 0; s < NSLOT; s++) begin
			bus_slots_o[s] = {busm_q[2*s], busm_q[2*s+1]}; // R5
		end
	end

	// ==========================================================
	// configuration
	cmon_sync2 #(
		.W (1)
	) u_pin_sync (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (timer_enable_pin_i),
		.sync_o    (timer_pin_s)
	);

	// the watchdog returns the reference to its default
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			keep_ref_q <= KEEP_RST;
		end else if (wdt_timeout_i) begin
			keep_ref_q <= KEEP_RST; // R6
		end else if (wr_en && avs_address_i == OFF_REF_CTRL && avs_byteenable_i[0]) begin
			keep_ref_q <= avs_writedata_i[REF_KEEP_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			under_code_q <= UNDER_RST; // R8
		end else if (wr_en && avs_address_i == OFF_UNDER) begin
			under_code_q <= (under_code_q & ~wmask[THR_W-1:0])
				| (avs_writedata_i[THR_W-1:0] & wmask[THR_W-1:0]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			over_code_q <= OVER_RST; // R9
		end else if (wr_en && avs_address_i == OFF_OVER) begin
			over_code_q <= (over_code_q & ~wmask[THR_W-1:0])
				| (avs_writedata_i[THR_W-1:0] & wmask[THR_W-1:0]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			drain_q <= DRAIN_RST; // R10
		end else if (wr_en && avs_address_i == OFF_DRAIN) begin
			drain_q <= (drain_q & ~wmask[NCELL-1:0])
				| (avs_writedata_i[NCELL-1:0] & wmask[NCELL-1:0]);
		end
	end

	// ==========================================================
	// analog controls
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ref_power_q <= 1'b0;
		end else begin
			ref_power_q <= conv_busy_i | keep_ref_q; // R6
		end
	end

	assign ref_power_o    = ref_power_q;
	assign drain_switch_o = drain_q; // R10

	// ==========================================================
	// interrupts
	always_comb begin
		irq_ev               = '0;
		irq_ev[IRQ_AUXB]     = auxb_valid_i;
		irq_ev[IRQ_STAT]     = stat_valid_i;
		irq_ev[IRQ_FLAG]     = cells_valid_i
			& (|((under_c & ~under_flag_q) | (over_c & ~over_flag_q)));
		irq_ev[IRQ_SELFTEST] = selftest_fail_i & ~selftest_q;
		irq_ev[IRQ_THERMAL]  = thermal_i & ~thermal_q;
	end

	// the read that captures the status also clears exactly those bits;
	// an event in that same cycle survives because set wins
	assign irq_clr = (rd_first && avs_address_i == OFF_IRQ_STAT) ? irq_stat_q : '0;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_mask_q <= MASK_RST;
		end else if (wr_en && avs_address_i == OFF_IRQ_MASK && avs_byteenable_i[0]) begin
			irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign irq_o = irq_q;

	// ==========================================================
	// read path
	// result and status groups only decode on reads, so writes there
	// fall through and change nothing
	always_comb begin
		rd_data_c = 32'h0000_0000;
		if (in_auxb) begin
			rd_data_c[7:0] = auxb_b[grp_idx]; // R11
		end else if (in_sta) begin
			rd_data_c[7:0] = sta_b[grp_idx]; // R11
		end else if (in_stb) begin
			rd_data_c[7:0] = stb_b[grp_idx]; // R11
		end else if (in_busm) begin
			rd_data_c[7:0] = busm_q[grp_idx];
		end else begin
			case (avs_address_i)
				OFF_REF_CTRL: begin
					rd_data_c[REF_KEEP_BIT]  = keep_ref_q;
					rd_data_c[TIMER_PIN_BIT] = timer_pin_s; // R7
				end
				OFF_UNDER: begin
					rd_data_c[THR_W-1:0] = under_code_q;
				end
				OFF_OVER: begin
					rd_data_c[THR_W-1:0] = over_code_q;
				end
				OFF_DRAIN: begin
					rd_data_c[NCELL-1:0] = drain_q;
				end
				OFF_IRQ_STAT: begin
					rd_data_c[IRQ_W-1:0] = irq_stat_q;
				end
				OFF_IRQ_MASK: begin
					rd_data_c[IRQ_W-1:0] = irq_mask_q;
				end
				default: begin
					rd_data_c = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			readdata_q <= 32'h0000_0000;
		end else if (rd_first) begin
			readdata_q <= rd_data_c;
		end
	end

	assign avs_readdata_o = readdata_q;

endmodule

// ### tb/cmon_bank_props.sv
// checker for cmon_bank: bus wait, config outputs, read layout
// assumes it is bound onto cmon_bank, one clock domain
module cmon_bank_props
	import cmon_pkg::*;
#(
	parameter logic [3:0] REVISION = REV_DEF
) (
	input wire logic                  clk_sys_i,         // clock
	input wire logic                  sys_rst_i,         // reset
	input wire logic [7:0]            avs_address_i,     // address
	input wire logic                  avs_read_i,        // read
	input wire logic                  avs_write_i,       // write
	input wire logic [31:0]           avs_writedata_i,   // write data
	input wire logic [3:0]            avs_byteenable_i,  // lanes
	input wire logic [31:0]           avs_readdata_o,    // read data
	input wire logic                  avs_waitrequest_o, // stall
	input wire logic                  conv_busy_i,       // busy
	input wire logic                  wdt_timeout_i,     // watchdog
	input wire logic                  ref_power_o,       // reference on
	input wire logic [NCELL-1:0]      drain_switch_o,    // switches
	input wire cmon_pkg::cmon_slots_t bus_slots_o        // slots
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====
	// helpers
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic        wr_done;
	logic        rd_done;
	logic [31:0] wd_q;
	assign wr_done = avs_write_i && !avs_waitrequest_o;
	assign rd_done = avs_read_i && !avs_waitrequest_o;
	always_ff @(posedge clk_sys_i) begin
		wd_q <= avs_writedata_i;
	end
	sequence s_keep_set;
		wr_done && avs_address_i == OFF_REF_CTRL && avs_byteenable_i[0]
			&& avs_writedata_i[REF_KEEP_BIT] && !wdt_timeout_i;
	endsequence
	sequence s_wdt_quiet;
		wdt_timeout_i && !avs_write_i ##1 !conv_busy_i && !avs_write_i;
	endsequence
	// ====
	// properties
	property p_wait_one;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	property p_drain_wr;
		wr_done && avs_address_i == OFF_DRAIN && avs_byteenable_i[1:0] == 2'b11
			|=> drain_switch_o == wd_q[11:0];
	endproperty
	property p_drain_hold;
		!(wr_done && avs_address_i == OFF_DRAIN) |=> $stable(drain_switch_o);
	endproperty
	property p_slot_first;
		wr_done && avs_address_i == OFF_BUSM && avs_byteenable_i[0] |=>
			{bus_slots_o[0].leading_control_code, bus_slots_o[0].transfer_byte[7:4]} == wd_q[7:0];
	endproperty
	property p_slot_last;
		wr_done && avs_address_i == OFF_BUSM + 8'h14 && avs_byteenable_i[0] |=>
			{bus_slots_o[2].transfer_byte[3:0], bus_slots_o[2].trailing_control_code} == wd_q[7:0];
	endproperty
	property p_ref_busy;
		conv_busy_i |=> ref_power_o;
	endproperty
	property p_ref_keep;
		s_keep_set |=> ##1 ref_power_o;
	endproperty
	property p_ref_wdt;
		s_wdt_quiet |=> !ref_power_o;
	endproperty
	property p_rev_byte;
		rd_done && avs_address_i == OFF_STB + 8'h14 |->
			avs_readdata_o[7:4] == REVISION && avs_readdata_o[3:2] == 2'b00;
	endproperty
	property p_upper_zero;
		rd_done && avs_address_i < OFF_REF_CTRL |-> avs_readdata_o[31:8] == 24'h000000;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("stall longer than one cycle");
	a_drain_wr: assert property (p_drain_wr) else $error("drain write lost");
	a_drain_hold: assert property (p_drain_hold) else $error("drain moved");
	a_slot_first: assert property (p_slot_first) else $error("slot 0 byte");
	a_slot_last: assert property (p_slot_last) else $error("slot 2 byte");
	a_ref_busy: assert property (p_ref_busy) else $error("reference off in use");
	a_ref_keep: assert property (p_ref_keep) else $error("reference not kept");
	a_ref_wdt: assert property (p_ref_wdt) else $error("reference kept");
	a_rev_byte: assert property (p_rev_byte) else $error("last status byte");
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
endmodule

// ### tb/cmon_host.sv
// host model: avalon-mm master that reaches the register bank
// assumes rd and wr are called from one process at a time
module cmon_host (
	input  wire logic        clk_sys_i,        // clock
	output logic      [7:0]  avs_address_o,    // address
	output logic             avs_read_o,       // read
	output logic             avs_write_o,      // write
	output logic      [31:0] avs_writedata_o,  // write data
	output logic      [3:0]  avs_byteenable_o, // lanes
	input  wire logic [31:0] avs_readdata_i,   // read data
	input  wire logic        avs_waitrequest_i // stall
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		avs_address_o = 8'h00;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_writedata_o = 32'h0;
		avs_byteenable_o = 4'h0;
	end
	// stall and read data are taken at the rising edge that ends the wait
	task automatic complete(output logic [31:0] d);
		@(posedge clk_sys_i);
		while (avs_waitrequest_i !== 1'b0) begin
			@(posedge clk_sys_i);
		end
		d = avs_readdata_i;
	endtask
	// slot bytes go whole, one byte register per word
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		@(posedge clk_sys_i);
		avs_address_o <= a;
		avs_writedata_o <= d;
		avs_byteenable_o <= be;
		avs_write_o <= 1'b1;
		complete(r);
		avs_write_o <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_o <= a;
		avs_read_o <= 1'b1;
		complete(d);
		avs_read_o <= 1'b0;
	endtask
endmodule

// ### tb/cmon_bank_bench.sv
// self-checking bench for the cell monitor register bank
// assumes cmon_host as bus master; the checker is bound below
module cmon_bank_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cmon_pkg::*;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [11:0] d;
		logic [11:0] e;
	} cmon_row_t;
	// ====
	// ordinary accesses: address, write?, data, expected read
	localparam cmon_row_t ROWS [20] = '{
		'{8'h00, 1'b1, 12'h0FF, 12'h034}, '{8'h04, 1'b0, 12'h000, 12'h012},
		'{8'h08, 1'b0, 12'h000, 12'h078}, '{8'h0C, 1'b0, 12'h000, 12'h056},
		'{8'h10, 1'b0, 12'h000, 12'h0BC}, '{8'h14, 1'b0, 12'h000, 12'h09A},
		'{8'h18, 1'b0, 12'h000, 12'h068}, '{8'h1C, 1'b1, 12'h000, 12'h024},
		'{8'h20, 1'b0, 12'h000, 12'h057}, '{8'h24, 1'b0, 12'h000, 12'h013},
		'{8'h28, 1'b0, 12'h000, 12'h0DC}, '{8'h2C, 1'b0, 12'h000, 12'h0FE},
		'{8'h30, 1'b1, 12'hFFF, 12'h05A}, '{8'h34, 1'b0, 12'h000, 12'h0A5},
		'{8'h48, 1'b1, 12'h0A5, 12'h0A5}, '{8'h5C, 1'b1, 12'h03C, 12'h03C},
		'{8'h64, 1'b1, 12'hFFF, 12'hFFF}, '{8'h68, 1'b1, 12'hABC, 12'hABC},
		'{8'h6C, 1'b1, 12'h801, 12'h801}, '{8'h7C, 1'b1, 12'hFFF, 12'h000}};
	localparam int LIMIT = 5000;
	logic        clk_sys = 1'b0, sys_rst = 1'b1;
	logic [7:0]  address;
	logic        rd_en, wr_en, stall, irq, ref_power;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0]  lanes;
	logic [11:0] drain;
	logic [15:0] dsup = 16'h0;
	logic        auxb_valid = 1'b0, stat_valid = 1'b0, cells_valid = 1'b0, selftest = 1'b0;
	logic        thermal = 1'b0, busy = 1'b0, wdt = 1'b0, pin = 1'b0;
	cmon_auxb_t  auxb = '0;
	cmon_stata_t stata = '0;
	cmon_cells_t cells = '0;
	cmon_slots_t slots;
	int          errors = 0, comparisons = 0, cycles = 0;
	cmon_bank #(.REVISION(4'hA)) i_cmon_bank (
		.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .avs_address_i(address),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_byteenable_i(lanes), .avs_readdata_o(rdata), .avs_waitrequest_o(stall),
		.irq_o(irq), .auxb_i(auxb), .auxb_valid_i(auxb_valid), .stata_i(stata),
		.digital_supply_i(dsup), .stat_valid_i(stat_valid), .cells_i(cells),
		.cells_valid_i(cells_valid), .selftest_fail_i(selftest), .thermal_i(thermal),
		.conv_busy_i(busy), .wdt_timeout_i(wdt), .timer_enable_pin_i(pin),
		.ref_power_o(ref_power), .drain_switch_o(drain), .bus_slots_o(slots));
	cmon_host i_cmon_host (
		.clk_sys_i(clk_sys), .avs_address_o(address), .avs_read_o(rd_en),
		.avs_write_o(wr_en), .avs_writedata_o(wdata), .avs_byteenable_o(lanes),
		.avs_readdata_i(rdata), .avs_waitrequest_i(stall));
	// ====
	// checking and closing
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rcheck(input logic [7:0] a, input logic [47:0] exp);
		i_cmon_host.rd(a, rd_val);
		check($sformatf("reg %h", a), {16'h0, rd_val}, exp);
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("Error run expected done seen hang");
			finish_test();
		end
	end
	// ====
	// tests
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rcheck(OFF_REF_CTRL + 8'(4 * i), 48'h0);
		end
		check("outputs", {35'h0, ref_power, drain}, 48'h0);
		check("slots", slots, 48'h0);
		$display("test reset done");
		auxb <= {16'h1234, 16'h5678, 16'h9ABC};
		stata <= {16'h2468, 16'h1357, 16'hFEDC};
		dsup <= 16'hA55A;
		auxb_valid <= 1'b1;
		stat_valid <= 1'b1;
		@(posedge clk_sys);
		auxb_valid <= 1'b0;
		stat_valid <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			if (ROWS[i].w) begin
				i_cmon_host.wr(ROWS[i].a, {20'h0, ROWS[i].d}, 4'hF);
			end
			rcheck(ROWS[i].a, {36'h0, ROWS[i].e});
		end
		check("drain", {36'h0, drain}, 48'h801);
		check("slots", slots, 48'h003C_0000_A500);
		$display("test table done");
		check("irq", {47'h0, irq}, 48'h0);
		i_cmon_host.wr(OFF_IRQ_MASK, 32'h1, 4'hF);
		repeat (2) @(posedge clk_sys);
		check("irq", {47'h0, irq}, 48'h1);
		rcheck(OFF_IRQ_STAT, 48'h3);
		rcheck(OFF_IRQ_STAT, 48'h0);
		check("irq", {47'h0, irq}, 48'h0);
		$display("test interrupt done");
		// levels land on both sides of each boundary: under 0x1000, over 0x2000
		i_cmon_host.wr(OFF_UNDER, 32'h0FF, 4'hF);
		i_cmon_host.wr(OFF_OVER, 32'h200, 4'hF);
		cells <= {16'h0000, 16'h1800, 16'h1800, 16'hFFFF, {4{16'h1800}},
			16'h2001, 16'h2000, 16'h1000, 16'h0FFF};
		cells_valid <= 1'b1;
		selftest <= 1'b1;
		thermal <= 1'b1;
		@(posedge clk_sys);
		cells_valid <= 1'b0;
		rcheck(OFF_STB + 8'h08, 48'h081);
		rcheck(OFF_STB + 8'h0C, 48'h000);
		rcheck(OFF_STB + 8'h10, 48'h042);
		rcheck(OFF_STB + 8'h14, 48'h0A3);
		rcheck(OFF_IRQ_STAT, 48'h1C);
		$display("test flags done");
		i_cmon_host.wr(OFF_REF_CTRL, 32'h3, 4'hF);
		rcheck(OFF_REF_CTRL, 48'h1);
		check("ref", {47'h0, ref_power}, 48'h1);
		pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rcheck(OFF_REF_CTRL, 48'h3);
		wdt <= 1'b1;
		@(posedge clk_sys);
		wdt <= 1'b0;
		repeat (2) @(posedge clk_sys);
		check("ref", {47'h0, ref_power}, 48'h0);
		rcheck(OFF_REF_CTRL, 48'h2);
		busy <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check("ref", {47'h0, ref_power}, 48'h1);
		busy <= 1'b0;
		$display("test reference done");
		finish_test();
	end
endmodule
bind cmon_bank cmon_bank_props #(.REVISION(REVISION)) i_cmon_bank_props (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .conv_busy_i(conv_busy_i),
	.wdt_timeout_i(wdt_timeout_i), .ref_power_o(ref_power_o),
	.drain_switch_o(drain_switch_o), .bus_slots_o(bus_slots_o));
